// ---- hdl/conv_ctrl_consts.svh ----
// offsets, field positions, reset values and counts for the converter control block
//
// Operation
// [R1] Three identical converter instances each have a control, a code-high and a code-low register and share one load register.
// [R2] Control bit 7 enables the instance when set and disables it when clear.
// [R3] Control bit 6 picks the code format: one is left justified, zero is right justified.
// [R4] Left justified: high bits 7..0 hold code 9..2, low bits 7..6 hold code 1..0, low bits 5..0 read zero.
// [R5] Right justified: high bits 7..2 read zero, high bits 1..0 hold code 9..8, the low byte holds code 7..0.
// [R6] Control bit 5 routes the converter output to the first output pin, clear disconnects it.
// [R7] Control bit 4 routes the converter output to the second output pin, clear disconnects it.
// [R8] The positive source field picks supply, the external pin or fixed reference two; software keeps off code 11.
// [R9] The negative source field picks analog ground or the first pin; code 10 is the second pin on the third instance only; 11 is reserved.
// [R10] Writing one to a load bit copies that instance's code registers into its buffer, then the bit clears itself.
// [R11] While a load bit is zero the buffer keeps its contents whatever the code registers do.
// [R12] The load register holds the load bits at positions 4, 1 and 0; every other bit reads zero.
// [R13] Code register writes reach the output only on a load, and all ten bits change together.
// [R14] Reset disables each instance, disconnects both pins and clears all ten code bits.
// [R15] Each instance drives its buffered code, enable, pin routes and source selects to the ladder on the edge after the load.
// Only the code waits for the load; enable, pin routes and source selects follow a control write one edge after it lands.
// [R16] A change of format only changes the register-to-code mapping and never touches the buffer by itself.
`ifndef CONV_CTRL_CONSTS_SVH
`define CONV_CTRL_CONSTS_SVH

// register byte addresses
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CTRL_C 8'h08
`define OFS_HIGH_A 8'h0C
`define OFS_HIGH_B 8'h10
`define OFS_HIGH_C 8'h14
`define OFS_LOW_A 8'h18
`define OFS_LOW_B 8'h1C
`define OFS_LOW_C 8'h20
`define OFS_LOAD 8'h24

// control register fields
`define BIT_EN 7
`define BIT_FMT 6
`define BIT_ROUTE1 5
`define BIT_ROUTE2 4
`define POS_HI 3
`define POS_LO 2
`define NEG_HI 1
`define NEG_LO 0

// load register fields
`define LOAD_BIT_A 0
`define LOAD_BIT_B 1
`define LOAD_BIT_C 4

// reset values and counts
`define CTRL_RST 8'h00
`define CODE_RST 8'h00
`define BUF_RST 10'h000
`define CODE_W 10
`define NUM_CONV 3

`endif

// ---- hdl/conv_ctrl_pkg.sv ----
// types shared by the converter control block
package conv_ctrl_pkg;
   typedef logic [9:0] code_t;
   typedef enum logic [1:0] {
      POS_SUPPLY = 2'b00,
      POS_EXT_PIN = 2'b01,
      POS_FIXED_REF = 2'b10,
      POS_RSVD = 2'b11
   } pos_src_t;
   typedef enum logic [1:0] {
      NEG_GROUND = 2'b00,
      NEG_PIN_FIRST = 2'b01,
      NEG_PIN_SECOND = 2'b10,
      NEG_RSVD = 2'b11
   } neg_src_t;
   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_CTRL = 3'b001,
      REG_HIGH = 3'b010,
      REG_LOW = 3'b011,
      REG_LOAD = 3'b100
   } reg_kind_t;
   typedef enum logic {
      ST_WAIT = 1'b0,
      ST_READY = 1'b1
   } apb_state_t;
endpackage

// ---- hdl/conv_link_if.sv ----
// settings passed from the register file to one converter instance
`timescale 1ns/1ns
interface conv_link_if;
   logic [7:0] ctrl;
   conv_ctrl_pkg::code_t code;
   logic load;
   modport src (output ctrl, output code, output load);
   modport sink (input ctrl, input code, input load);
endinterface

// ---- hdl/conv_channel.sv ----
// one converter instance: code double buffer and ladder-side outputs
`timescale 1ns/1ns
`include "conv_ctrl_consts.svh"
module conv_channel #(
   parameter bit NEG_SECOND_OK = 1'b0
) (
   // clock and synchronised reset
   input logic clk_in,
   input logic rst_b_in,
   // settings from the register file
   conv_link_if.sink link,
   // toward the ladder and source multiplexers
   output logic enable_out,
   output logic route_first_out,
   output logic route_second_out,
   output conv_ctrl_pkg::pos_src_t pos_sel_out,
   output conv_ctrl_pkg::neg_src_t neg_sel_out,
   output conv_ctrl_pkg::code_t code_out
);
   import conv_ctrl_pkg::*;

   code_t buf_r;
   logic enable_r;
   logic route1_r;
   logic route2_r;
   pos_src_t pos_r;
   pos_src_t pos_nxt;
   neg_src_t neg_r;
   neg_src_t neg_nxt;

   if ($bits(code_t) != `CODE_W) begin : g_chk
      $error("code type width does not match the converter");
   end

   // reserved selections fall back to the rail ends so the ladder never floats
   always_comb begin
      pos_nxt = pos_src_t'(link.ctrl[`POS_HI:`POS_LO]);
      if (pos_nxt == POS_RSVD) begin
         pos_nxt = POS_SUPPLY; // R8
      end
      neg_nxt = neg_src_t'(link.ctrl[`NEG_HI:`NEG_LO]);
      if (neg_nxt == NEG_RSVD || (neg_nxt == NEG_PIN_SECOND && !NEG_SECOND_OK)) begin
         neg_nxt = NEG_GROUND; // R9
      end
   end

   // double buffer: only a load pulse moves the composed code in
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         buf_r <= `BUF_RST; // R14
      end else if (link.load) begin
         buf_r <= link.code; // R10 R13 R15
      end
   end // R11 R16

   // control copies, one edge behind the register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         enable_r <= 1'b0; // R14
         route1_r <= 1'b0;
         route2_r <= 1'b0;
         pos_r <= POS_SUPPLY;
         neg_r <= NEG_GROUND;
      end else begin
         enable_r <= link.ctrl[`BIT_EN]; // R2
         route1_r <= link.ctrl[`BIT_ROUTE1]; // R6
         route2_r <= link.ctrl[`BIT_ROUTE2]; // R7
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
      end
   end

   // outputs straight from the flops
   assign enable_out = enable_r;
   assign route_first_out = route1_r;
   assign route_second_out = route2_r;
   assign pos_sel_out = pos_r;
   assign neg_sel_out = neg_r;
   assign code_out = buf_r; // R15
endmodule

// ---- hdl/conv_ctrl_top.sv ----
// register file and APB slave for three ten-bit converter instances
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "conv_ctrl_consts.svh"
module conv_ctrl_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input logic mclk_in,
   input logic rst_b_in,
   // APB slave
   input logic psel_in,
   input logic penable_in,
   input logic pwrite_in,
   input logic [ADDR_W-1:0] paddr_in,
   input logic [31:0] pwdata_in,
   input logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // per instance, index 0 = a, 1 = b, 2 = c
   output logic [2:0] enable_out,
   output logic [2:0] pin_route_first_out,
   output logic [2:0] pin_route_second_out,
   output logic [5:0] positive_source_sel_out,
   output logic [5:0] negative_source_sel_out,
   output logic [29:0] code_out
);
   import conv_ctrl_pkg::*;

   // reset synchroniser
   logic rst_meta_r;
   logic rst_sync_r;

   // register storage, raw bytes as written
   logic [7:0] ctrl_r [`NUM_CONV];
   logic [7:0] high_r [`NUM_CONV];
   logic [7:0] low_r [`NUM_CONV];
   logic [2:0] load_r;
   logic [2:0] load_nxt;

   // bus side
   apb_state_t state_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata_nxt;
   reg_kind_t kind;
   logic [1:0] idx;
   logic [7:0] addr8;
   logic access;
   logic wr_fire;
   logic [7:0] wbyte;
   logic [2:0] we_ctrl;
   logic [2:0] we_high;
   logic [2:0] we_low;
   logic we_load;

   // composed codes and readback views
   code_t code_w [`NUM_CONV];
   logic [7:0] high_view [`NUM_CONV];
   logic [7:0] low_view [`NUM_CONV];

   // the decode compares against 8-bit offsets
   if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
      $error("ADDR_W must lie between 6 and 32");
   end

   // release reset through two flops, assert at once
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // upper address bits beyond the map make the access unmapped
   always_comb begin
      addr8 = 8'(paddr_in);
      if (ADDR_W > 8) begin
         if (paddr_in >> 8 != '0) begin
            addr8 = 8'hFF;
         end
      end
   end

   // address decode
   always_comb begin
      kind = REG_NONE;
      idx = 2'd0;
      if (addr8 == `OFS_CTRL_A) begin
         kind = REG_CTRL;
         idx = 2'd0;
      end else if (addr8 == `OFS_CTRL_B) begin
         kind = REG_CTRL;
         idx = 2'd1;
      end else if (addr8 == `OFS_CTRL_C) begin
         kind = REG_CTRL;
         idx = 2'd2;
      end else if (addr8 == `OFS_HIGH_A) begin
         kind = REG_HIGH;
         idx = 2'd0;
      end else if (addr8 == `OFS_HIGH_B) begin
         kind = REG_HIGH;
         idx = 2'd1;
      end else if (addr8 == `OFS_HIGH_C) begin
         kind = REG_HIGH;
         idx = 2'd2;
      end else if (addr8 == `OFS_LOW_A) begin
         kind = REG_LOW;
         idx = 2'd0;
      end else if (addr8 == `OFS_LOW_B) begin
         kind = REG_LOW;
         idx = 2'd1;
      end else if (addr8 == `OFS_LOW_C) begin
         kind = REG_LOW;
         idx = 2'd2;
      end else if (addr8 == `OFS_LOAD) begin
         kind = REG_LOAD;
      end
   end

   // a write lands only on the edge where the master sees pready high
   assign access = psel_in && penable_in;
   assign wr_fire = access && pready_r && pwrite_in && pstrb_in[0];
   assign wbyte = pwdata_in[7:0];

   // one write enable per register, so each store below is a plain guarded copy
   always_comb begin
      we_ctrl = 3'b000;
      we_high = 3'b000;
      we_low = 3'b000;
      we_load = 1'b0;
      if (wr_fire) begin
         if (kind == REG_CTRL) begin
            we_ctrl[idx] = 1'b1;
         end else if (kind == REG_HIGH) begin
            we_high[idx] = 1'b1;
         end else if (kind == REG_LOW) begin
            we_low[idx] = 1'b1;
         end else if (kind == REG_LOAD) begin
            we_load = 1'b1;
         end
      end
   end

   // code composition and readback per instance
   for (genvar i = 0; i < `NUM_CONV; i++) begin : g_view
      always_comb begin
         if (ctrl_r[i][`BIT_FMT]) begin // R3
            code_w[i] = {high_r[i], low_r[i][7:6]}; // R4
            high_view[i] = high_r[i];
            low_view[i] = {low_r[i][7:6], 6'h00}; // R4
         end else begin
            code_w[i] = {high_r[i][1:0], low_r[i]}; // R5
            high_view[i] = {6'h00, high_r[i][1:0]}; // R5
            low_view[i] = low_r[i];
         end
      end
   end

   // read multiplexer, narrow data in the low byte
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (kind == REG_CTRL) begin
         rdata_nxt[7:0] = ctrl_r[idx];
      end else if (kind == REG_HIGH) begin
         rdata_nxt[7:0] = high_view[idx];
      end else if (kind == REG_LOW) begin
         rdata_nxt[7:0] = low_view[idx];
      end else if (kind == REG_LOAD) begin
         rdata_nxt[`LOAD_BIT_A] = load_r[0]; // R12
         rdata_nxt[`LOAD_BIT_B] = load_r[1];
         rdata_nxt[`LOAD_BIT_C] = load_r[2];
      end
   end

   // one wait state: answer prepared on the first access edge
   always_ff @(posedge mclk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= ST_WAIT;
         pready_r <= 1'b0;
      end else begin
         case (state_r)
            ST_WAIT: begin
               if (access) begin
                  state_r <= ST_READY;
                  pready_r <= 1'b1;
               end
            end
            ST_READY: begin
               state_r <= ST_WAIT;
               pready_r <= 1'b0;
            end
            default: begin
               state_r <= ST_WAIT;
               pready_r <= 1'b0;
            end
         endcase
      end
   end

   // read data, held while pready stands
   always_ff @(posedge mclk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         prdata_r <= 32'h0000_0000;
      end else if (state_r == ST_WAIT && access) begin
         prdata_r <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
      end else if (state_r == ST_READY) begin
         prdata_r <= 32'h0000_0000;
      end
   end

   // error answer only for holes in the map
   always_ff @(posedge mclk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pslverr_r <= 1'b0;
      end else if (state_r == ST_WAIT && access) begin
         pslverr_r <= (kind == REG_NONE);
      end else if (state_r == ST_READY) begin
         pslverr_r <= 1'b0;
      end
   end

   // control registers steer the instances
   for (genvar i = 0; i < `NUM_CONV; i++) begin : g_regs
      always_ff @(posedge mclk_in or negedge rst_sync_r) begin
         if (!rst_sync_r) begin
            ctrl_r[i] <= `CTRL_RST; // R14
         end else if (we_ctrl[i]) begin
            ctrl_r[i] <= wbyte; // R1 R8 R9
         end
      end

      // raw bytes are kept whole so a format flip only remaps them
      always_ff @(posedge mclk_in or negedge rst_sync_r) begin
         if (!rst_sync_r) begin
            high_r[i] <= `CODE_RST; // R14
         end else if (we_high[i]) begin
            high_r[i] <= wbyte; // R13 R16
         end
      end

      always_ff @(posedge mclk_in or negedge rst_sync_r) begin
         if (!rst_sync_r) begin
            low_r[i] <= `CODE_RST; // R14
         end else if (we_low[i]) begin
            low_r[i] <= wbyte; // R13 R16
         end
      end
   end

   // load bits live one cycle: a fresh set wins over the self clear
   always_comb begin
      load_nxt = 3'b000;
      if (we_load) begin
         load_nxt[0] = wbyte[`LOAD_BIT_A]; // R12
         load_nxt[1] = wbyte[`LOAD_BIT_B];
         load_nxt[2] = wbyte[`LOAD_BIT_C];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         load_r <= 3'b000;
      end else begin
         load_r <= load_nxt; // R10
      end
   end

   // one link and one channel per instance; only c has the second negative pin
   for (genvar i = 0; i < `NUM_CONV; i++) begin : g_conv
      conv_link_if link ();
      pos_src_t pos_sel;
      neg_src_t neg_sel;
      code_t code_buf;

      assign link.ctrl = ctrl_r[i];
      assign link.code = code_w[i];
      assign link.load = load_r[i]; // R11

      conv_channel #(
         .NEG_SECOND_OK(i == `NUM_CONV - 1)
      ) u_chan (
         .clk_in(mclk_in),
         .rst_b_in(rst_sync_r),
         .link(link.sink),
         .enable_out(enable_out[i]),
         .route_first_out(pin_route_first_out[i]),
         .route_second_out(pin_route_second_out[i]),
         .pos_sel_out(pos_sel),
         .neg_sel_out(neg_sel),
         .code_out(code_buf)
      );

      assign positive_source_sel_out[2*i+1:2*i] = pos_sel;
      assign negative_source_sel_out[2*i+1:2*i] = neg_sel;
      assign code_out[10*i+9:10*i] = code_buf; // R15
   end

   // bus outputs straight from flops
   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
endmodule

// ---- tb/conv_ctrl_monitor.sv ----
// assertion checker for the converter control register block
`timescale 1ns/1ns
`include "conv_ctrl_consts.svh"
module conv_ctrl_monitor #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input logic mclk_in,
   input logic rst_b_in,
   // apb side
   input logic psel_in,
   input logic penable_in,
   input logic pwrite_in,
   input logic [ADDR_W-1:0] paddr_in,
   input logic [31:0] pwdata_in,
   input logic [3:0] pstrb_in,
   input logic [31:0] prdata_out,
   input logic pready_out,
   input logic pslverr_out,
   // ladder side
   input logic [2:0] enable_out,
   input logic [2:0] pin_route_first_out,
   input logic [2:0] pin_route_second_out,
   input logic [5:0] positive_source_sel_out,
   input logic [5:0] negative_source_sel_out,
   input logic [29:0] code_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // a write lands only on the completing edge, and only with the low strobe
   logic done;
   logic wr_ok;
   logic ld_a;
   logic ld_c;
   assign done = psel_in && penable_in && pready_out;
   assign wr_ok = done && pwrite_in && pstrb_in[0];
   assign ld_a = wr_ok && paddr_in == `OFS_LOAD && pwdata_in[`LOAD_BIT_A];
   assign ld_c = wr_ok && paddr_in == `OFS_LOAD && pwdata_in[`LOAD_BIT_C];
   sequence s_wait;
      psel_in && penable_in && !pready_out;
   endsequence
   sequence s_answer;
      pready_out ##1 !pready_out;
   endsequence
   property p_one_wait;
      s_wait |=> s_answer;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("apb answer timing wrong");
   property p_enable;
      wr_ok && paddr_in == `OFS_CTRL_A |=> ##1 enable_out[0] == $past(pwdata_in[7], 2);
   endproperty
   a_enable: assert property (p_enable) else $error("enable does not follow write");
   property p_route;
      wr_ok && paddr_in == `OFS_CTRL_A |=> ##1
         {pin_route_first_out[0], pin_route_second_out[0]} == $past(pwdata_in[5:4], 2);
   endproperty
   a_route: assert property (p_route) else $error("pin routes do not follow write");
   property p_pos_sel;
      positive_source_sel_out[1:0] != 2'b11 && positive_source_sel_out[3:2] != 2'b11
         && positive_source_sel_out[5:4] != 2'b11;
   endproperty
   a_pos_sel: assert property (p_pos_sel) else $error("reserved positive source");
   property p_neg_sel;
      !negative_source_sel_out[1] && !negative_source_sel_out[3]
         && negative_source_sel_out[5:4] != 2'b11;
   endproperty
   a_neg_sel: assert property (p_neg_sel) else $error("reserved negative source");
   property p_hold_a;
      $changed(code_out[9:0]) |-> $past(ld_a, 2);
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("code a moved without load");
   property p_hold_c;
      $changed(code_out[29:20]) |-> $past(ld_c, 2);
   endproperty
   a_hold_c: assert property (p_hold_c) else $error("code c moved without load");
   property p_load_zero;
      done && !pwrite_in && paddr_in == `OFS_LOAD |-> prdata_out == 32'h0000_0000;
   endproperty
   a_load_zero: assert property (p_load_zero) else $error("load register not zero");
   property p_unmapped;
      done && paddr_in > `OFS_LOAD |-> pslverr_out && prdata_out == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule
bind conv_ctrl_top conv_ctrl_monitor #(.ADDR_W(ADDR_W)) mon_u (.mclk_in(mclk_in),
   .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .enable_out(enable_out),
   .pin_route_first_out(pin_route_first_out), .pin_route_second_out(pin_route_second_out),
   .positive_source_sel_out(positive_source_sel_out),
   .negative_source_sel_out(negative_source_sel_out), .code_out(code_out));

// ---- tb/ladder_model.sv ----
// behavioural resistor ladder: tap level of each converter instance
`timescale 1ns/1ns
module ladder_model (
   // settings from the control block
   input wire logic [2:0] enable_in,
   input wire logic [29:0] code_in,
   // ladder tap per instance
   output logic [29:0] level_out
);
   // a disabled ladder draws no current, so its tap sits at zero
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         level_out[10*i +: 10] = enable_in[i] ? code_in[10*i +: 10] : 10'h000;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "conv_ctrl_consts.svh"
module tb_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] en;
   logic [2:0] rt1;
   logic [2:0] rt2;
   logic [5:0] pos;
   logic [5:0] neg;
   logic [29:0] code;
   logic [29:0] level;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   conv_ctrl_top #(.ADDR_W(8)) dut_u (.mclk_in(mclk), .rst_b_in(rst_b), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .enable_out(en), .pin_route_first_out(rt1), .pin_route_second_out(rt2),
      .positive_source_sel_out(pos), .negative_source_sel_out(neg), .code_out(code));
   ladder_model ladder_u (.enable_in(en), .code_in(code), .level_out(level));
   // 10 MHz clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard, the whole run needs well under two thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up;
      end
   end
   // one apb transfer; request held until pready is seen at an edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, {24'h0, d}, 4'hF);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      xfer(a, 1'b0, 32'h0, 4'hF);
      check(rd, {24'h0, exp});
      check({31'h0, err}, 32'h0);
   endtask
   // outputs follow a write one edge after it lands
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   initial begin
      logic [1:0] ep;
      do_reset;
      for (int i = 0; i < 10; i++) begin
         rd_chk(8'(4 * i), 8'h00);
      end
      check({en, rt1, rt2, pos, neg}, 32'h0);
      check(code, 32'h0);
      // unmapped read is refused, a strobe-less write is ignored without an error
      xfer(8'h28, 1'b0, 32'h0, 4'hF);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      xfer(`OFS_CTRL_A, 1'b1, 32'hFF, 4'h0);
      rd_chk(`OFS_CTRL_A, 8'h00);
      wr(`OFS_CTRL_A, 8'hB9);
      rd_chk(`OFS_CTRL_A, 8'hB9);
      check({en[0], rt1[0], rt2[0], pos[1:0], neg[1:0]}, 32'h79);
      // every source code on every instance, reserved ones fall back to 00
      for (int i = 0; i < 3; i++) begin
         for (int c = 0; c < 16; c++) begin
            wr(8'(4 * i), {4'h8, 4'(c)});
            settle;
            ep = (c[3:2] == 2'b11) ? 2'b00 : 2'(c >> 2);
            check(pos[2*i +: 2], ep);
            ep = (c[1:0] == 2'b11 || (c[1:0] == 2'b10 && i != 2)) ? 2'b00 : 2'(c);
            check(neg[2*i +: 2], ep);
         end
      end
      wr(`OFS_CTRL_A, 8'h80);
      wr(`OFS_HIGH_A, 8'hFF);
      wr(`OFS_LOW_A, 8'h5A);
      wr(`OFS_HIGH_C, 8'h12);
      wr(`OFS_LOW_C, 8'h34);
      rd_chk(`OFS_HIGH_A, 8'h03);
      rd_chk(`OFS_LOW_A, 8'h5A);
      check({rt1[0], rt2[0], code[19:0]}, 32'h0);
      wr(`OFS_LOAD, 8'h01);
      settle;
      check(code[9:0], 10'h35A);
      check(code[29:20], 10'h000);
      rd_chk(`OFS_LOAD, 8'h00);
      // format change remaps readback only, buffer untouched
      wr(`OFS_CTRL_A, 8'hC0);
      rd_chk(`OFS_HIGH_A, 8'hFF);
      rd_chk(`OFS_LOW_A, 8'h40);
      check(code[9:0], 10'h35A);
      // single load bits reach only their own instance, then all bits set load all three
      wr(`OFS_HIGH_B, 8'h01);
      wr(`OFS_LOW_B, 8'hC3);
      wr(`OFS_LOAD, 8'h10);
      settle;
      check(code, {10'h234, 10'h000, 10'h35A});
      wr(`OFS_LOAD, 8'hEE);
      settle;
      check(code, {10'h234, 10'h1C3, 10'h35A});
      wr(`OFS_LOAD, 8'hFF);
      settle;
      check(code, {10'h234, 10'h1C3, 10'h3FD});
      check(level, {10'h234, 10'h1C3, 10'h3FD});
      // a disabled instance leaves its tap at zero
      wr(`OFS_CTRL_B, 8'h0F);
      settle;
      check(level, {10'h234, 10'h000, 10'h3FD});
      rd_chk(`OFS_LOAD, 8'h00);
      do_reset;
      check(code, 32'h0);
      check({en, rt1, rt2, pos, neg}, 32'h0);
      rd_chk(`OFS_HIGH_A, 8'h00);
      wrap_up;
   end
endmodule
